// *** src/sfis_pkg.sv ***
// Purpose: shared constants and carriers of the flash interface states
// Assumes: 250 MHz ref_clk
// Notes:   command codes pick the transfer format of a command
package sfis_pkg;

	// ----------------------------------------------------------------
	// timing and widths
	// ----------------------------------------------------------------
	localparam int         CLK_NS   = 4;
	localparam int         TMR_W    = 20;
	localparam logic [1:0] ADDR_N   = 2'h3;
	localparam logic [2:0] W0       = 3'h0;
	localparam logic [2:0] W1       = 3'h1;
	localparam logic [2:0] W2       = 3'h2;
	localparam logic [2:0] W4       = 3'h4;
	localparam logic [3:0] OE_NONE  = 4'h0;
	localparam logic [3:0] OE_SO    = 4'h2;
	localparam logic [3:0] OE_DUAL  = 4'h3;
	localparam logic [3:0] OE_ALL   = 4'hf;
	localparam logic [3:0] BYTES_MX = 4'hf;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_WREG = 8'h01;
	localparam logic [7:0] CMD_PP   = 8'h02;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_FRD  = 8'h0b;
	localparam logic [7:0] CMD_DOR  = 8'h3b;
	localparam logic [7:0] CMD_QOR  = 8'h6b;
	localparam logic [7:0] CMD_WANY = 8'h71;
	localparam logic [7:0] CMD_RELP = 8'hab;
	localparam logic [7:0] CMD_PDWN = 8'hb9;
	localparam logic [7:0] CMD_DIOR = 8'hbb;
	localparam logic [7:0] CMD_QIOR = 8'heb;
	localparam logic [7:0] CMD_DDRQ = 8'hed;

	typedef enum logic [14:0] {
		ST_OFF    = 15'h0001,
		ST_POR    = 15'h0002,
		ST_WRST   = 15'h0004,
		ST_STBY   = 15'h0008,
		ST_INSTR  = 15'h0010,
		ST_SIN    = 15'h0020,
		ST_DIN    = 15'h0040,
		ST_QIN    = 15'h0080,
		ST_DDRIN  = 15'h0100,
		ST_LAT    = 15'h0200,
		ST_SOUT   = 15'h0400,
		ST_DOUT   = 15'h0800,
		ST_QOUT   = 15'h1000,
		ST_DDROUT = 15'h2000,
		ST_RESW   = 15'h4000
	} sfis_state_t;

	// pins as seen by the device; io[0]=si, io[1]=so, io[2]=wp, io[3]=rst
	typedef struct packed {
		logic       vok;
		logic       vcut;
		logic       cs_n;
		logic       sck;
		logic [3:0] io;
	} sfis_pins_t;

	typedef struct packed {
		logic [2:0] in_w;
		logic [1:0] addr_n;
		logic [2:0] out_w;
		logic       ddr;
		logic       lat;
		logic       alone;
		logic       wreg;
	} sfis_fmt_t;

	typedef struct packed {
		sfis_state_t      st;
		sfis_pins_t       s1;
		sfis_pins_t       s2;
		sfis_pins_t       s3;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] rcnt;
		logic [7:0]       sr;
		logic [7:0]       instr;
		logic [7:0]       tx;
		logic [7:0]       code;
		sfis_fmt_t        fmt;
		logic [2:0]       w;
		logic [2:0]       bitc;
		logic [2:0]       obit;
		logic [3:0]       bytes;
		logic [3:0]       lat;
		logic [3:0]       lat_tot;
		logic [3:0]       io_o;
		logic [3:0]       io_oe;
		logic             pdn;
		logic             wp;
		logic             exec;
		logic             rej;
		logic             take;
		logic             push;
		logic             ovr;
	} sfis_st_t;

	function automatic int sfis_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

endpackage

// *** src/sfis_buf.sv ***
// Purpose: two-entry valid/ready buffer on the received byte path
// Assumes: one clock, registered outputs
// Notes:   in_ready drops only while both entries hold data
module sfis_buf #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,   // core clock
	input  wire logic         resetn,    // sync reset, low active
	input  wire logic         in_valid,  // word offered
	input  wire logic [W-1:0] in_data,   // word
	output logic              in_ready,  // room for a word
	output logic              out_valid, // head word present
	output logic      [W-1:0] out_data,  // head word
	input  wire logic         out_ready  // sink takes head
);
	typedef struct packed {
		logic [W-1:0] head;
		logic [W-1:0] tail;
		logic         hv;
		logic         tv;
		logic         rdy;
	} sfis_buf_st_t;

	sfis_buf_st_t q;
	sfis_buf_st_t d;

	always_comb begin
		d = q;
		if (q.hv && out_ready) begin
			d.head = q.tail;
			d.hv   = q.tv;
			d.tv   = 1'b0;
		end
		if (in_valid && q.rdy) begin
			if (!d.hv) begin
				d.head = in_data;
				d.hv   = 1'b1;
			end else begin
				d.tail = in_data;
				d.tv   = 1'b1;
			end
		end
		d.rdy = !d.tv;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q     <= '0;
			q.rdy <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign in_ready  = q.rdy;
	assign out_valid = q.hv;
	assign out_data  = q.head;

	a_buf_no_loss: assert property (@(posedge ref_clk) disable iff (!resetn)
		(in_valid && in_ready && !(out_valid && out_ready)) |=> out_valid)
		else $error("accepted word not held");
endmodule

// *** src/sfis_core.sv ***
// Purpose: interface state machine of a serial nor flash device
// Assumes: sck, cs_n, io and supply flags are asynchronous pins
// Notes:   sck is oversampled; bits are taken on synced edges
//
// Function
// - powered off: ignore pins, nothing runs
// - below cut-off: discard commands
// - power-on reset silent, then standby
// - io3 is reset if not quad or cs high
// - reset after pulse, recovery, then hold
// - cs high: standby, only reset heard
// - cs falling in standby starts instruction
// - deep power-down only when not busy
// - deep power-down obeys only release command
// - single mode: msb first, eight rising edges
// - write-protect sampled only for register writes
// - instruction picks format and next state
// - stand-alone ends after eighth bit
// - four-bit mode with quad enable takes nibble instructions
// - single input: serial output undriven
// - after input go latency, then output
// - dual output drives io0 and io1
// - quad output drives all four lines
// - ddr latency: device floats all lines
// - cs off byte boundary in an input state rejects command
// - quad enable needed for quad commands
module sfis_core #(
	parameter int T_PU_NS  = 300000,
	parameter int T_RP_NS  = 200,
	parameter int T_RPH_NS = 35000,
	parameter int T_RH_NS  = 50,
	parameter int T_RES_NS = 3000
) (
	input  wire logic                     ref_clk,   // core clock
	input  wire logic                     resetn,    // sync reset, low
	input  wire sfis_pkg::sfis_pins_t     pins,      // raw pin levels
	input  wire logic                     quad_enable,    // quad io mode
	input  wire logic                     four_bit_instruction_mode, // nibble
	input  wire logic                     hw_reset_enable, // io3_or_hw_reset_n
	input  wire logic                     write_in_progress, // busy
	input  wire logic [3:0]               latency_code,   // dummy cycles
	input  wire logic [7:0]               tx_data,   // next read byte
	input  wire logic                     rx_ready,  // sink takes byte
	output logic      [3:0]               io_out,    // io drive values
	output logic      [3:0]               io_oe,     // io drive enables
	output sfis_pkg::sfis_state_t         state,     // interface state
	output logic                          cmd_exec,  // command accepted
	output logic      [7:0]               cmd_code,  // accepted code
	output logic                          cmd_reject, // cs off boundary
	output logic                          wp_level,  // sampled wp
	output logic                          deep_power_down, // power-down on
	output logic                          tx_take,   // tx_data consumed
	output logic                          rx_valid,  // received byte
	output logic      [7:0]               rx_data,   // byte value
	output logic                          overrun    // byte dropped
);
	import sfis_pkg::*;

	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	localparam int PU_CYC  = sfis_cyc(T_PU_NS);
	localparam int RP_CYC  = sfis_cyc(T_RP_NS);
	localparam int RPH_CYC = sfis_cyc(T_RPH_NS);
	localparam int RH_CYC  = sfis_cyc(T_RH_NS);
	localparam int RES_CYC = sfis_cyc(T_RES_NS);

	sfis_st_t q;
	sfis_st_t d;
	logic     buf_rdy;
	logic     do_drv;
	logic     byte_ok;
	logic     nib_ins;
	logic     rst_req;
	logic     in_ph;
	logic     out_ph;
	logic     sck_rise;
	logic     sck_fall;
	logic     cs_rise;
	logic     cs_fall;
	logic [7:0] src;

	assign sck_rise = q.s2.sck && !q.s3.sck;
	assign sck_fall = !q.s2.sck && q.s3.sck;
	assign cs_rise  = q.s2.cs_n && !q.s3.cs_n;
	assign cs_fall  = !q.s2.cs_n && q.s3.cs_n;
	assign nib_ins  = four_bit_instruction_mode && quad_enable;
	assign rst_req  = hw_reset_enable && !q.s2.io[3]
		&& (!quad_enable || q.s2.cs_n);
	assign in_ph    = q.st inside {ST_INSTR, ST_SIN, ST_DIN, ST_QIN,
		ST_DDRIN};
	assign out_ph   = q.st inside {ST_SOUT, ST_DOUT, ST_QOUT, ST_DDROUT};

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic sfis_fmt_t decode(input logic [7:0] c,
		input logic qp, input logic qen);
		sfis_fmt_t f;
		f      = '0;
		f.in_w = W1;
		case (c)
			CMD_READ: begin
				f.addr_n = ADDR_N;
				f.out_w  = W1;
			end
			CMD_FRD, CMD_DOR, CMD_QOR: begin
				f.addr_n = ADDR_N;
				f.lat    = 1'b1;
				f.out_w  = (c == CMD_FRD) ? W1 : (c == CMD_DOR) ? W2 : W4;
			end
			CMD_DIOR, CMD_QIOR, CMD_DDRQ: begin
				f.addr_n = ADDR_N;
				f.lat    = 1'b1;
				f.in_w   = (c == CMD_DIOR) ? W2 : W4;
				f.out_w  = f.in_w;
				f.ddr    = (c == CMD_DDRQ);
			end
			CMD_PP:   f.addr_n = ADDR_N;
			CMD_WREG: f.wreg = 1'b1;
			CMD_WANY: begin
				f.wreg   = 1'b1;
				f.addr_n = ADDR_N;
			end
			default:  f.alone = 1'b1;
		endcase
		if (!qen && (f.in_w == W4 || f.out_w == W4)) begin
			f       = '0;
			f.in_w  = W1;
			f.alone = 1'b1;
		end
		if (qp) begin
			f.in_w = W4;
			if (f.out_w != W0) f.out_w = W4;
		end
		return f;
	endfunction

	function automatic sfis_state_t in_st(input logic [2:0] w,
		input logic ddr);
		return (w == W1) ? ST_SIN : (w == W2) ? ST_DIN :
			ddr ? ST_DDRIN : ST_QIN;
	endfunction

	function automatic sfis_state_t out_st(input logic [2:0] w,
		input logic ddr);
		return (w == W1) ? ST_SOUT : (w == W2) ? ST_DOUT :
			ddr ? ST_DDROUT : ST_QOUT;
	endfunction

	function automatic logic [3:0] oe_of(input logic [2:0] w);
		return (w == W1) ? OE_SO : (w == W2) ? OE_DUAL : OE_ALL;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d        = q;
		d.s1     = pins;
		d.s2     = q.s1;
		d.s3     = q.s2;
		d.exec   = 1'b0;
		d.rej    = 1'b0;
		d.take   = 1'b0;
		d.push   = 1'b0;
		do_drv   = 1'b0;
		byte_ok  = q.bitc == W0 && q.bytes != 4'h0
			&& (!q.fmt.alone || q.bytes == 4'h1);
		src      = (q.obit == W0) ? tx_data : q.tx;
		if (!q.s2.vok) begin
			d.st    = ST_OFF;
			d.io_oe = OE_NONE;
			d.pdn   = 1'b0;
		end else if (q.st == ST_OFF) begin
			d.st  = ST_POR;
			d.tmr = '0;
		end else if (q.st == ST_POR) begin
			d.tmr = q.tmr + 1'b1;
			if (q.tmr == TMR_W'(PU_CYC - 1)) d.st = ST_STBY;
		end else if (q.st == ST_WRST) begin
			if (q.tmr != TMR_W'(RPH_CYC)) d.tmr = q.tmr + 1'b1;
			if (!q.s2.io[3]) d.rcnt = '0;
			else if (q.rcnt != TMR_W'(RH_CYC)) d.rcnt = q.rcnt + 1'b1;
			if (q.tmr == TMR_W'(RPH_CYC) && q.rcnt == TMR_W'(RH_CYC)) begin
				d.st   = ST_STBY;
				d.rcnt = '0;
			end
		end else if (rst_req && q.rcnt == TMR_W'(RP_CYC - 1)) begin
			d.st    = ST_WRST;
			d.tmr   = '0;
			d.rcnt  = '0;
			d.io_oe = OE_NONE;
			d.pdn   = 1'b0;
		end else begin
			d.rcnt = rst_req ? q.rcnt + 1'b1 : '0;
			if (cs_rise && q.st != ST_STBY && q.st != ST_RESW) begin
				d.st    = ST_STBY;
				d.io_oe = OE_NONE;
				if (in_ph && !byte_ok) begin
					d.rej = 1'b1;
				end else if (in_ph && q.s2.vcut
					&& (!q.pdn || q.instr == CMD_RELP)) begin
					d.exec = 1'b1;
					d.code = q.instr;
					if (q.instr == CMD_PDWN && !write_in_progress)
						d.pdn = 1'b1;
					if (q.pdn) begin
						d.st  = ST_RESW;
						d.tmr = '0;
						d.pdn = 1'b0;
					end
				end
			end else begin
				unique case (q.st)
					ST_STBY: begin
						d.io_oe = OE_NONE;
						if (cs_fall) begin
							d.st    = ST_INSTR;
							d.bitc  = W0;
							d.bytes = 4'h0;
							d.sr    = 8'h00;
							d.w     = nib_ins ? W4 : W1;
						end
					end
					ST_RESW: begin
						d.tmr = q.tmr + 1'b1;
						if (q.tmr == TMR_W'(RES_CYC - 1)) d.st = ST_STBY;
					end
					ST_INSTR, ST_SIN, ST_DIN, ST_QIN, ST_DDRIN: begin
						d.io_oe = OE_NONE;
						if (sck_rise || (q.st == ST_DDRIN && sck_fall)) begin
							unique case (q.w)
								W1:      d.sr = {q.sr[6:0], q.s2.io[0]};
								W2:      d.sr = {q.sr[5:0], q.s2.io[1:0]};
								default: d.sr = {q.sr[3:0], q.s2.io};
							endcase
							d.bitc = q.bitc + q.w;
							if (d.bitc == W0) begin
								if (q.bytes != BYTES_MX) d.bytes = q.bytes + 1'b1;
								if (!q.pdn && q.s2.vcut) begin
									if (buf_rdy) d.push = 1'b1;
									else d.ovr = 1'b1;
								end
								if (q.st == ST_INSTR) begin
									d.instr = d.sr;
									d.fmt   = decode(d.sr, nib_ins, quad_enable);
									if (d.fmt.wreg && !q.pdn)
										d.wp = q.s2.io[2];
									if (q.pdn || d.fmt.alone) begin
										d.w  = nib_ins ? W4 : W1;
										d.st = nib_ins ? ST_QIN : ST_SIN;
									end else begin
										d.w  = d.fmt.in_w;
										d.st = in_st(d.fmt.in_w, d.fmt.ddr);
									end
								end else if (!q.pdn && q.fmt.out_w != W0
									&& d.bytes == {2'b00, q.fmt.addr_n} + 4'h1) begin
									d.st      = ST_LAT;
									d.lat     = 4'h0;
									d.obit    = W0;
									d.lat_tot = q.fmt.lat ? latency_code : 4'h0;
								end
							end
						end
					end
					ST_LAT: begin
						d.io_oe = OE_NONE;
						if (sck_fall) begin
							if (q.lat == q.lat_tot) begin
								d.st    = out_st(q.fmt.out_w, q.fmt.ddr);
								d.w     = q.fmt.out_w;
								d.io_oe = oe_of(q.fmt.out_w);
								do_drv  = 1'b1;
							end else begin
								d.lat = q.lat + 1'b1;
							end
						end
					end
					ST_SOUT, ST_DOUT, ST_QOUT, ST_DDROUT: begin
						d.io_oe = oe_of(q.w);
						do_drv  = sck_fall || (q.st == ST_DDROUT && sck_rise);
					end
					default: d.st = ST_STBY;
				endcase
			end
		end
		if (do_drv) begin
			unique case (d.w)
				W1: begin
					d.io_o = {2'b00, src[7], 1'b0};
					d.tx   = {src[6:0], 1'b0};
				end
				W2: begin
					d.io_o = {2'b00, src[7:6]};
					d.tx   = {src[5:0], 2'b00};
				end
				default: begin
					d.io_o = src[7:4];
					d.tx   = {src[3:0], 4'h0};
				end
			endcase
			d.take = (q.obit == W0);
			d.obit = q.obit + d.w;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q    <= '0;
			q.st <= ST_OFF;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// received byte buffer
	// ----------------------------------------------------------------
	sfis_buf #(.W(8)) u_buf (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.in_valid  (q.push),
		.in_data   (q.sr),
		.in_ready  (buf_rdy),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);

	assign io_out          = q.io_o;
	assign io_oe           = q.io_oe;
	assign state           = q.st;
	assign cmd_exec        = q.exec;
	assign cmd_code        = q.code;
	assign cmd_reject      = q.rej;
	assign wp_level        = q.wp;
	assign deep_power_down = q.pdn;
	assign tx_take         = q.take;
	assign overrun         = q.ovr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_off_no_drive: assert property (!q.s2.vok |=> io_oe == OE_NONE
		&& state == ST_OFF) else $error("drive while off");
	a_cutoff_no_exec: assert property (cmd_exec |-> $past(q.s2.vcut))
		else $error("exec below cut-off");
	a_por_quiet: assert property ($rose(state == ST_POR) |->
		(io_oe == OE_NONE && !cmd_exec)[*8])
		else $error("por not quiet");
	a_stby_to_instr: assert property (state == ST_STBY && cs_fall
		&& q.s2.vok && !rst_req |=> state == ST_INSTR)
		else $error("no instruction start");
	a_dpd_only_idle: assert property ($rose(deep_power_down) |->
		$past(!write_in_progress)) else $error("sleep while busy");
	a_wp_sample: assert property ($changed(wp_level) |->
		$past(state) == ST_INSTR) else $error("wp sampled late");
	a_si_no_drive: assert property (state inside {ST_INSTR, ST_SIN} |->
		!io_oe[1]) else $error("so driven in input");
	a_dual_drive: assert property (state == ST_DOUT |-> io_oe == OE_DUAL)
		else $error("dual drive wrong");
	a_quad_drive: assert property (state inside {ST_QOUT, ST_DDROUT}
		|-> io_oe == OE_ALL) else $error("quad drive wrong");
	a_lat_float: assert property (state == ST_LAT |-> io_oe == OE_NONE)
		else $error("latency driven");
	a_cs_rise_end: assert property ((in_ph || out_ph || state == ST_LAT)
		&& cs_rise |=> state inside {ST_STBY, ST_RESW, ST_WRST, ST_OFF})
		else $error("transfer not abandoned");
	a_reject_exec: assert property (cmd_reject |-> $past(q.bitc) != W0
		|| $past(q.bytes) == 4'h0 || $past(q.fmt.alone))
		else $error("bad reject");
endmodule

// *** tb/sfis_host.sv ***
// Purpose: host controller model driving the flash interface pins
// Assumes: sck half period of 4 ref_clk cycles, mode 0
// Notes:   sck idles low outside frames; io3 held high by the host except in four-bit transfers
module sfis_host (
	input  wire logic       ref_clk, // core clock
	input  wire logic       wp,      // write-protect level to drive
	input  wire logic [3:0] io,      // resolved io lines
	output logic            cs_n,    // chip select, low active
	output logic            sck,     // serial clock
	output logic      [3:0] h_out,   // host drive values
	output logic      [3:0] h_oe     // host drive enables
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n  = 1'b1;
		sck   = 1'b0;
		h_out = 4'h8;
		h_oe  = 4'h8;
	end

	task automatic half();
		repeat (4) @(posedge ref_clk);
	endtask

	// frames open from standby or, in t_power, from off; io3 stays high
	task automatic start();
		cs_n <= 1'b0;
		half();
	endtask

	task automatic stop();
		cs_n  <= 1'b1;
		h_oe  <= 4'h8;
		h_out <= 4'h8;
		half();
	endtask

	// msb first, lsb of a group on io0
	task automatic send(input logic [7:0] d, input int w, input int nb);
		logic [3:0] g;
		for (int k = 0; k < nb; k += w) begin
			g = 4'(d >> (8 - k - w));
			h_oe  <= (w == 4) ? 4'hf : (w == 2) ? 4'hb : 4'hd;
			h_out <= (w == 4) ? g :
				{1'b1, wp, (w == 2) ? g[1:0] : {1'b0, g[0]}};
			half();
			sck <= 1'b1;
			half();
			sck <= 1'b0;
		end
	endtask

	// lines are sampled at the end of the high phase
	task automatic read(input int w, output logic [7:0] b);
		logic [3:0] g;
		h_oe  <= (w == 4) ? 4'h0 : 4'h8;
		h_out <= 4'h8;
		half();
		for (int k = 0; k < 8; k += w) begin
			sck <= 1'b1;
			repeat (3) @(posedge ref_clk);
			@(negedge ref_clk);
			g = (w == 1) ? {3'b0, io[1]} : (w == 2) ? {2'b0, io[1:0]} : io;
			b = (b << w) | {4'h0, g};
			@(posedge ref_clk);
			sck <= 1'b0;
			half();
		end
	endtask
endmodule

// *** tb/sfis_core_test.sv ***
// Purpose: self-checking bench of the flash interface states
// Assumes: shortened timing parameters, 4 ns ref_clk
// Notes:   undriven io0/io1 toggle, io2/io3 pulled high
module sfis_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sfis_pkg::*;

	logic        ref_clk = 1'b0, resetn = 1'b0, vok = 1'b0, vcut = 1'b1;
	logic        qe = 1'b0, nib_mode = 1'b0, hwen = 1'b0, busy = 1'b0;
	logic        rx_ready = 1'b1, flt = 1'b0, wp_pin = 1'b1, rst_pin = 1'b1;
	logic [3:0]  lat_c = 4'h0, io, io_out, io_oe, h_out, h_oe;
	logic [7:0]  tx = 8'ha5, cmd_code, rx_data, last_rx;
	logic        cs_n, sck, cmd_exec, cmd_reject, wp_level, pwr_dn;
	logic        tx_take, rx_valid, overrun, ex = 1'b0, rj = 1'b0;
	logic        tk = 1'b0;
	sfis_state_t state;
	sfis_pins_t  pins;
	int          err_total = 0, checked = 0;

	assign pins = '{vok, vcut, cs_n, sck, io};
	always #2 ref_clk = ~ref_clk;

	always_comb begin
		for (int i = 0; i < 4; i++)
			io[i] = io_oe[i] ? io_out[i] : h_oe[i] ? h_out[i] :
				(i < 2) ? flt : 1'b1;
		io[3] = io[3] & (io_oe[3] | rst_pin);
	end

	always @(posedge ref_clk) begin
		flt <= ~flt;
		if (cmd_exec)
			ex <= 1'b1;
		if (cmd_reject)
			rj <= 1'b1;
		if (tx_take)
			tk <= 1'b1;
		if (rx_valid && rx_ready)
			last_rx <= rx_data;
	end

	sfis_core #(.T_PU_NS(80), .T_RP_NS(16), .T_RPH_NS(40), .T_RH_NS(8),
		.T_RES_NS(40)) uut (
		.ref_clk(ref_clk), .resetn(resetn), .pins(pins),
		.quad_enable(qe), .four_bit_instruction_mode(nib_mode),
		.hw_reset_enable(hwen), .write_in_progress(busy),
		.latency_code(lat_c), .tx_data(tx), .rx_ready(rx_ready),
		.io_out(io_out), .io_oe(io_oe), .state(state),
		.cmd_exec(cmd_exec), .cmd_code(cmd_code), .cmd_reject(cmd_reject),
		.wp_level(wp_level), .deep_power_down(pwr_dn), .tx_take(tx_take),
		.rx_valid(rx_valid), .rx_data(rx_data), .overrun(overrun));

	sfis_host host (.ref_clk(ref_clk), .wp(wp_pin), .io(io), .cs_n(cs_n),
		.sck(sck), .h_out(h_out), .h_oe(h_oe));

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [14:0] g, input logic [14:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_st(input sfis_state_t g, input sfis_state_t e);
		chk(g, e);
	endtask

	task automatic wait_st(input sfis_state_t s, input int n);
		for (int i = 0; i < n && state !== s; i++)
			@(posedge ref_clk);
		chk_st(state, s);
	endtask

	task automatic cmd(input logic [7:0] d, input int w, input int nb);
		ex <= 1'b0;
		rj <= 1'b0;
		host.start();
		host.send(d, w, nb);
		host.stop();
		repeat (8) @(posedge ref_clk);
	endtask

	task automatic close_out();
		$display("mismatches %0d of %0d compares", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_power();
		cmd(8'h06, 1, 8);
		chk(ex, 1'b0);
		chk_st(state, ST_OFF);
		chk(io_oe, OE_NONE);
		vok <= 1'b1;
		wait_st(ST_POR, 6);
		chk(io_oe, OE_NONE);
		wait_st(ST_STBY, 40);
	endtask

	task automatic t_alone();
		host.send(8'h06, 1, 8);
		chk_st(state, ST_STBY);
		chk(ex, 1'b0);
		host.start();
		wait_st(ST_INSTR, 8);
		host.send(8'h06, 1, 8);
		chk(io_oe, OE_NONE);
		host.stop();
		repeat (8) @(posedge ref_clk);
		chk(ex, 1'b1);
		chk(cmd_code, 8'h06);
		chk(last_rx, 8'h06);
		chk_st(state, ST_STBY);
		cmd(8'h06, 1, 5);
		chk(rj, 1'b1);
		chk(ex, 1'b0);
	endtask

	task automatic t_wp();
		wp_pin <= 1'b0;
		cmd(8'h01, 1, 8);
		chk(wp_level, 1'b0);
		wp_pin <= 1'b1;
		cmd(8'h06, 1, 8);
		chk(wp_level, 1'b0);
		cmd(8'h01, 1, 8);
		chk(wp_level, 1'b1);
	endtask

	task automatic t_sleep();
		busy <= 1'b1;
		cmd(8'hb9, 1, 8);
		chk(pwr_dn, 1'b0);
		busy <= 1'b0;
		cmd(8'hb9, 1, 8);
		chk(pwr_dn, 1'b1);
		cmd(8'h06, 1, 8);
		chk(ex, 1'b0);
		host.start();
		host.send(8'hab, 1, 8);
		host.stop();
		wait_st(ST_RESW, 6);
		wait_st(ST_STBY, 20);
		chk(pwr_dn, 1'b0);
	endtask

	task automatic t_read();
		logic [7:0]  b;
		logic [7:0]  op [3] = '{8'h03, 8'h3b, 8'h6b};
		logic [3:0]  oe [3] = '{OE_SO, OE_DUAL, OE_ALL};
		sfis_state_t sx [3] = '{ST_SOUT, ST_DOUT, ST_QOUT};
		for (int i = 0; i < 3; i++) begin
			qe <= (i == 2);
			tk <= 1'b0;
			host.start();
			host.send(op[i], 1, 8);
			repeat (3) host.send(8'h00, 1, 8);
			host.read(1 << i, b);
			chk(b, 8'ha5);
			chk(tk, 1'b1);
			chk_st(state, sx[i]);
			chk(io_oe, oe[i]);
			host.stop();
			wait_st(ST_STBY, 8);
		end
		qe       <= 1'b1;
		nib_mode <= 1'b1;
		cmd(8'h06, 4, 8);
		chk(ex, 1'b1);
		chk(cmd_code, 8'h06);
		nib_mode <= 1'b0;
		vcut     <= 1'b0;
		cmd(8'h06, 1, 8);
		chk(ex, 1'b0);
		vcut <= 1'b1;
	endtask

	task automatic t_warm();
		hwen <= 1'b1;
		host.start();
		rst_pin <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk_st(state, ST_INSTR);
		rst_pin <= 1'b1;
		host.stop();
		rst_pin <= 1'b0;
		wait_st(ST_WRST, 12);
		chk(io_oe, OE_NONE);
		repeat (20) @(posedge ref_clk);
		rst_pin <= 1'b1;
		wait_st(ST_STBY, 20);
		hwen <= 1'b0;
		qe   <= 1'b0;
	endtask

	// receiver stalls across four bytes, then drains
	task automatic t_stall();
		rx_ready <= 1'b0;
		host.start();
		repeat (4) host.send(8'h03, 1, 8);
		host.stop();
		repeat (8) @(posedge ref_clk);
		chk(overrun, 1'b1);
		chk(rx_valid, 1'b1);
		rx_ready <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk(rx_valid, 1'b0);
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		t_power();
		t_alone();
		t_wp();
		t_sleep();
		t_read();
		t_warm();
		t_stall();
		close_out();
	end

	initial begin
		#100000;
		err_total++;
		close_out();
	end
endmodule
